//--- rtl/hts_defs.svh
// Purpose: constants of the hall threshold self-calibration block
// Assumes: 10-bit field samples, 20 MHz clk
// Notes: all offsets, CTRL fields, resets and timing counts live here
`ifndef HTS_DEFS_SVH
`define HTS_DEFS_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define HTS_CLK_HZ 20000000
`define HTS_WDOG_S 12
`define HTS_WDOG_CYCLES (`HTS_WDOG_S * `HTS_CLK_HZ)

// ----------------------------------------------------------------
// field scale and algorithm figures
// ----------------------------------------------------------------
`define HTS_UT_PER_LSB 500
`define HTS_STEP_MT 15
`define HTS_STEP_LSB (`HTS_STEP_MT * 1000 / `HTS_UT_PER_LSB)
`define HTS_HYST_LSB 10'h004
`define HTS_DNC_LSB 10'h008
`define HTS_PHASE_SW 6'h10
`define HTS_WINDOW_SW 6'h20
`define HTS_SIGN_RUN 3'h4
`define HTS_EXT_LIMIT 3'h4
`define HTS_K0_HALF 8'h80

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define HTS_ADDR_CTRL 4'h0
`define HTS_ADDR_STATUS 4'h4
`define HTS_CTRL_TPO_LSB 0
`define HTS_CTRL_PROG_BIT 10
`define HTS_CTRL_INV_BIT 11
`define HTS_CTRL_K0_LSB 12
`define HTS_CTRL_ACT_LSB 20
`define HTS_K0_RESET 8'hb6
`define HTS_ACT_RESET 4'h2

`endif

//--- rtl/hts_pkg.sv
// Purpose: types of the hall threshold self-calibration block
// Assumes: nothing beyond hts_defs.svh
// Notes: whole state of the top is one packed struct
package hts_pkg;

  typedef enum logic [1:0] {
    HTS_INIT = 2'b00,
    HTS_PRECAL = 2'b01,
    HTS_CAL = 2'b10
  } hts_mode_type;

  typedef struct packed {
    hts_mode_type mode;
    logic sar_busy;
    logic [3:0] sar_bit;
    logic [9:0] sar_val;
    logic [9:0] thr;
    logic out_low;
    logic above;
    logic armed;
    logic rising;
    logic [9:0] run_max;
    logic [9:0] run_min;
    logic [9:0] last_max;
    logic [9:0] last_min;
    logic have_max;
    logic have_min;
    logic [9:0] hi_max;
    logic [9:0] lo_min;
    logic pend;
    logic signed [11:0] pend_delta;
    logic single_done;
    logic [5:0] sw_count;
    logic [2:0] sign_cnt;
    logic sign_pos;
    logic [27:0] wdog;
    logic [2:0] ext_cnt;
    logic [9:0] prev_f;
    logic [9:0] power_on_threshold;
    logic programmed;
    logic invert;
    logic [7:0] k0;
    logic [3:0] act;
    logic ack;
    logic [31:0] readdata;
  } hts_state_type;

endpackage

//--- rtl/hts_threshold_cal.sv
// Purpose: mode sequencing and threshold self-calibration of a hall tooth/notch sensor
// Assumes: field_sample is an unsigned 10-bit code, new value flagged by sample_valid
// Notes: avalon-mm slave with one wait state; open-drain output as q_out/q_oe_n
//
// The address map and the Avalon-MM register port are this design's own decisions.
`include "hts_defs.svh"

module hts_threshold_cal
  import hts_pkg::*;
#(
  parameter int WDOG_CYCLES = `HTS_WDOG_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [9:0] field_sample,
  input wire logic sample_valid,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic q_out,
  output logic q_oe_n
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  localparam logic signed [11:0] STEP = 12'(`HTS_STEP_LSB);
  localparam logic [27:0] WDOG_LAST = 28'(WDOG_CYCLES - 1);

  function automatic logic [9:0] target(input logic [9:0] mx, input logic [9:0] mn,
                                        input logic [7:0] k);
    logic [17:0] prod;
    prod = (mx >= mn) ? (18'(mx - mn) * 18'(k)) : 18'h00000;
    return mn + prod[17:8];
  endfunction

  function automatic logic signed [11:0] clamp_step(input logic signed [11:0] d);
    if (d > STEP) begin
      return STEP;
    end else if (d < -STEP) begin
      return -STEP;
    end
    return d;
  endfunction

  hts_state_type s;
  hts_state_type next_s;
  logic toggled;
  logic ext_ev;
  logic reinit;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [9:0] f;
    logic [9:0] trial;
    logic [10:0] up_lvl;
    logic [10:0] dn_lvl;
    logic [7:0] k;
    logic [9:0] tgt;
    logic signed [11:0] d;
    logic hidden;
    logic new_max;
    logic new_min;
    f = field_sample;
    trial = 10'h000;
    up_lvl = 11'(s.thr) + 11'(`HTS_HYST_LSB);
    dn_lvl = 11'(s.thr) - 11'(`HTS_HYST_LSB);
    k = s.programmed ? s.k0 : `HTS_K0_HALF;
    tgt = 10'h000;
    d = 12'sh000;
    hidden = (s.mode == HTS_CAL) || (s.programmed && s.mode == HTS_PRECAL);
    new_max = 1'b0;
    new_min = 1'b0;
    next_s = s;
    toggled = 1'b0;
    ext_ev = 1'b0;
    reinit = 1'b0;

    // avalon slave: one wait state, answer on second cycle
    next_s.ack = 1'b0;
    if ((read || write) && !s.ack) begin
      next_s.ack = 1'b1;
      unique case (address)
        `HTS_ADDR_CTRL: next_s.readdata = {8'h00, s.act, s.k0, s.invert, s.programmed, s.power_on_threshold};
        `HTS_ADDR_STATUS: next_s.readdata = {6'h00, s.thr, 2'b00, s.sw_count, 3'b000,
                                             s.sar_busy, s.out_low, 1'b0, s.mode};
        default: next_s.readdata = 32'h00000000;
      endcase
    end
    // one-time programmable: locked once the programmed bit is set
    if (write && s.ack && address == `HTS_ADDR_CTRL && !s.programmed) begin
      next_s.power_on_threshold = writedata[`HTS_CTRL_TPO_LSB +: 10];
      next_s.programmed = writedata[`HTS_CTRL_PROG_BIT];
      next_s.invert = writedata[`HTS_CTRL_INV_BIT];
      next_s.k0 = writedata[`HTS_CTRL_K0_LSB +: 8];
      next_s.act = writedata[`HTS_CTRL_ACT_LSB +: 4];
      reinit = writedata[`HTS_CTRL_PROG_BIT];
    end

    if (sample_valid) begin
      next_s.prev_f = f;
      if (s.sar_busy) begin
        // auto_search_mode: output held high until the search ends
        trial = s.sar_val | (10'h001 << s.sar_bit);
        if (f >= trial) begin
          next_s.sar_val = trial;
        end
        if (s.sar_bit == 4'h0) begin
          next_s.sar_busy = 1'b0;
          next_s.thr = (f >= trial) ? trial : s.sar_val;
          next_s.above = 1'b0;
        end else begin
          next_s.sar_bit = s.sar_bit - 4'h1;
        end
        next_s.out_low = 1'b0;
      end else begin
        // ----- output comparator
        if (hidden) begin
          // switch exactly at thr, re-armed by either hysteresis level
          if (s.armed && s.above && f < s.thr) begin
            next_s.above = 1'b0;
            next_s.armed = 1'b0;
          end else if (s.armed && !s.above && f > s.thr) begin
            next_s.above = 1'b1;
            next_s.armed = 1'b0;
          end else if (11'(f) > up_lvl || 11'(f) < dn_lvl) begin
            next_s.armed = 1'b1;
          end
        end else begin
          if (!s.above && 11'(f) > up_lvl) begin
            next_s.above = 1'b1;
          end else if (s.above && 11'(f) < dn_lvl) begin
            next_s.above = 1'b0;
          end
        end
        next_s.out_low = next_s.above ^ s.invert;
        toggled = next_s.out_low != s.out_low;

        // ----- valid_extremum_detect: extreme confirmed by retreat
        if (s.rising) begin
          if (f > s.run_max) begin
            next_s.run_max = f;
          end else if (11'(f) + 11'(`HTS_DNC_LSB) < 11'(s.run_max)) begin
            new_max = 1'b1;
            next_s.last_max = s.run_max;
            next_s.have_max = 1'b1;
            next_s.rising = 1'b0;
            next_s.run_min = f;
          end
        end else begin
          if (f < s.run_min) begin
            next_s.run_min = f;
          end else if (11'(f) > 11'(s.run_min) + 11'(`HTS_DNC_LSB)) begin
            new_min = 1'b1;
            next_s.last_min = s.run_min;
            next_s.have_min = 1'b1;
            next_s.rising = 1'b1;
            next_s.run_max = f;
          end
        end
        ext_ev = new_max || new_min;
        if (new_max && s.run_max > s.hi_max) begin
          next_s.hi_max = s.run_max;
        end
        if (new_min && s.run_min < s.lo_min) begin
          next_s.lo_min = s.run_min;
        end

        // ----- release offset only on the matching field edge
        // released ahead of the pair logic, so a fresh pair in this sample still lands
        if (s.pend && s.mode == HTS_PRECAL) begin
          if (s.pend_delta > 0 && f > s.prev_f) begin
            next_s.thr = 10'(12'(s.thr) + s.pend_delta);
            next_s.pend = 1'b0;
          end else if (s.pend_delta < 0 && f < s.prev_f) begin
            next_s.thr = 10'(12'(s.thr) + s.pend_delta);
            next_s.pend = 1'b0;
          end else if (s.pend_delta == 0) begin
            next_s.pend = 1'b0;
          end
        end

        // ----- precalibration on each min/max pair below 16 switches, then once on the window extremes; runs without switching too
        if (ext_ev && next_s.have_max && next_s.have_min && s.mode != HTS_CAL) begin
          if (s.mode == HTS_INIT) begin
            next_s.mode = HTS_PRECAL;
            next_s.sw_count = 6'h00;
          end
          if (s.mode == HTS_INIT || s.sw_count < `HTS_PHASE_SW) begin
            tgt = target(next_s.last_max, next_s.last_min, k);
            next_s.pend_delta = clamp_step(12'(tgt) - 12'(s.thr));
            next_s.pend = 1'b1;
          end else if (!s.single_done) begin
            tgt = target(next_s.hi_max, next_s.lo_min, k);
            next_s.pend_delta = clamp_step(12'(tgt) - 12'(s.thr));
            next_s.pend = 1'b1;
            next_s.single_done = 1'b1;
          end
        end

        // ----- switching events
        if (toggled && s.mode != HTS_INIT) begin
          next_s.sw_count = s.sw_count + 6'h01;
          if (s.sw_count + 6'h01 == `HTS_WINDOW_SW) begin
            next_s.sw_count = 6'h00;
            next_s.hi_max = 10'h000;
            next_s.lo_min = 10'h3ff;
            next_s.pend = 1'b0;
            if (s.mode == HTS_PRECAL) begin
              next_s.mode = HTS_CAL;
              next_s.sign_cnt = 3'h0;
            end else begin
              tgt = target(next_s.hi_max == 10'h000 ? s.hi_max : next_s.hi_max,
                           s.lo_min, k);
              d = 12'(tgt) - 12'(s.thr);
              if (d > $signed({8'h00, s.act}) || d < -$signed({8'h00, s.act})) begin
                if (s.sign_cnt != 3'h0 && s.sign_pos == (d > 0)) begin
                  next_s.sign_cnt = (s.sign_cnt == `HTS_SIGN_RUN) ? s.sign_cnt
                                                                  : s.sign_cnt + 3'h1;
                end else begin
                  next_s.sign_cnt = 3'h1;
                  next_s.sign_pos = d > 0;
                end
                if (next_s.sign_cnt == `HTS_SIGN_RUN) begin
                  next_s.thr = (d > 0) ? s.thr + 10'h001 : s.thr - 10'h001;
                end
              end
            end
          end
        end

        // ----- plausibility: extremes seen but output silent
        if (toggled) begin
          next_s.ext_cnt = 3'h0;
        end else if (ext_ev && s.mode == HTS_CAL) begin
          next_s.ext_cnt = s.ext_cnt + 3'h1;
          if (s.ext_cnt + 3'h1 == `HTS_EXT_LIMIT) begin
            reinit = 1'b1;
          end
        end
      end
    end

    // ----- watchdog
    if (toggled) begin
      next_s.wdog = 28'h0000000;
    end else if (s.wdog == WDOG_LAST) begin
      reinit = 1'b1;
    end else begin
      next_s.wdog = s.wdog + 28'h0000001;
    end

    // programmed part keeps its output level over re-init; a new search holds it high
    if (reinit) begin
      next_s.mode = HTS_INIT;
      next_s.sw_count = 6'h00;
      next_s.pend = 1'b0;
      next_s.single_done = 1'b0;
      next_s.sign_cnt = 3'h0;
      next_s.ext_cnt = 3'h0;
      next_s.wdog = 28'h0000000;
      next_s.have_max = 1'b0;
      next_s.have_min = 1'b0;
      next_s.hi_max = 10'h000;
      next_s.lo_min = 10'h3ff;
      next_s.armed = 1'b1;
      next_s.thr = next_s.programmed ? next_s.power_on_threshold : s.thr;
      next_s.sar_busy = !next_s.programmed;
      if (!next_s.programmed) begin
        next_s.out_low = 1'b0;
      end
      next_s.sar_bit = 4'h9;
      next_s.sar_val = 10'h000;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= '0;
      s.mode <= HTS_INIT;
      s.sar_busy <= 1'b1;
      s.sar_bit <= 4'h9;
      s.lo_min <= 10'h3ff;
      s.run_min <= 10'h3ff;
      s.rising <= 1'b1;
      s.armed <= 1'b1;
      s.k0 <= `HTS_K0_RESET;
      s.act <= `HTS_ACT_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign readdata = s.readdata;
  assign waitrequest = (read || write) && !s.ack;
  assign q_out = 1'b0;
  assign q_oe_n = !s.out_low;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_SAR_HIGH: assert property (@(posedge clk) disable iff (!reset_n)
    s.sar_busy |-> q_oe_n) else $error("output not high during search");

  AST_WDOG: assert property (@(posedge clk) disable iff (!reset_n)
    (s.wdog == WDOG_LAST && !toggled) |=> (s.mode == HTS_INIT && s.wdog == 28'h0000000))
    else $error("watchdog expiry did not re-init");

  AST_CAL_STEP: assert property (@(posedge clk) disable iff (!reset_n)
    (s.mode == HTS_CAL && !reinit) |=> (s.thr == $past(s.thr) ||
      s.thr == $past(s.thr) + 10'h001 || s.thr + 10'h001 == $past(s.thr)))
    else $error("calibrated step above one lsb");

  AST_PRE_EDGE: assert property (@(posedge clk) disable iff (!reset_n)
    (s.mode == HTS_PRECAL && next_s.mode == HTS_PRECAL && next_s.thr > s.thr)
      |-> (sample_valid && field_sample > s.prev_f))
    else $error("positive update off rising edge");

  AST_PRE_CLAMP: assert property (@(posedge clk) disable iff (!reset_n)
    (s.mode == HTS_PRECAL && !reinit) |=>
      (((s.thr >= $past(s.thr)) ? (s.thr - $past(s.thr)) : ($past(s.thr) - s.thr))
        <= 10'(`HTS_STEP_LSB)))
    else $error("precalibrated step too large");

  AST_POLARITY: assert property (@(posedge clk) disable iff (!reset_n)
    (sample_valid && !s.sar_busy && s.mode == HTS_INIT && !s.invert && !reinit &&
     11'(field_sample) > 11'(s.thr) + 11'(`HTS_HYST_LSB)) |=> !q_oe_n)
    else $error("tooth did not drive output low");

  AST_TO_CAL: assert property (@(posedge clk) disable iff (!reset_n)
    (s.mode == HTS_PRECAL && toggled && s.sw_count == 6'h1f && !reinit) |=> s.mode == HTS_CAL)
    else $error("no calibrated mode after 32 switches");

  AST_EXT_RESET: assert property (@(posedge clk) disable iff (!reset_n)
    (s.mode == HTS_CAL && ext_ev && !toggled && s.ext_cnt == 3'h3) |=> s.mode == HTS_INIT)
    else $error("silent extremes did not re-init");

  AST_BUS_WAIT: assert property (@(posedge clk) disable iff (!reset_n)
    ((read || write) && !waitrequest) |=> (waitrequest || !(read || write)))
    else $error("waitrequest not reasserted after answer");

endmodule

//--- dv/hts_controller_model.sv
// Purpose: engine controller side of the sensor's open-drain output line
// Assumes: pull-up resistor on the line, so a released pin reads high
// Notes: counts level changes seen on the line since reset
module hts_controller_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic q_out,
  input wire logic q_oe_n,
  output logic pin,
  output int edges
);
  timeunit 1ns;
  timeprecision 1ns;

  logic last;

  // ------------------------------------------------------------
  // line resolution
  // ------------------------------------------------------------
  // pull-up wins whenever the sensor lets go, never the last driven level
  assign pin = q_oe_n ? 1'b1 : q_out;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      last <= 1'b1;
      edges <= 0;
    end else begin
      last <= pin;
      if (pin != last) edges <= edges + 1;
    end
  end
endmodule

//--- dv/hts_threshold_cal_tb.sv
// Purpose: self-checking bench of the hall threshold self-calibration block
// Assumes: 20 MHz clk, watchdog shortened to 200 cycles
// Notes: triangle field waves stand in for a turning target wheel
module hts_threshold_cal_tb
  import hts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk;
  logic reset_n;
  logic [9:0] field_sample;
  logic sample_valid;
  logic [3:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic q_out;
  logic q_oe_n;
  logic pin;
  int edges;
  int bad_count;
  int tests_run;
  logic [31:0] rd;
  logic [9:0] thr;
  logic [9:0] prev;

  hts_threshold_cal #(.WDOG_CYCLES(200)) i_dut (
    .clk(clk), .reset_n(reset_n), .field_sample(field_sample),
    .sample_valid(sample_valid), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .q_out(q_out), .q_oe_n(q_oe_n)
  );

  hts_controller_model i_ctrl (
    .clk(clk), .reset_n(reset_n), .q_out(q_out), .q_oe_n(q_oe_n),
    .pin(pin), .edges(edges)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // samples pause during a bus cycle so the field never repeats unseen
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    sample_valid <= 1'b0;
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= d;
    n = 0;
    // waitrequest and readdata are taken as they stood at the edge itself
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) begin
      bad_count++;
      finish_test();
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic st;
    bus(1'b0, 4'h4, 32'h0);
  endtask

  task automatic smp(input logic [9:0] v);
    @(posedge clk);
    field_sample <= v;
    sample_valid <= 1'b1;
  endtask

  task automatic pin_is(input logic [9:0] v, input logic e);
    smp(v);
    @(posedge clk);
    sample_valid <= 1'b0;
    @(negedge clk);
    chk(32'(pin), 32'(e));
  endtask

  // one wheel period, 8 lsb per sample both ways
  task automatic wave(input logic [9:0] lo, input logic [9:0] hi);
    for (int v = lo; v < hi; v += 8) smp(v[9:0]);
    for (int v = hi; v > lo; v -= 8) smp(v[9:0]);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    field_sample = 10'h000;
    sample_valid = 1'b0;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    bad_count = 0;
    tests_run = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h002b6000);
    st();
    chk(rd & 32'h13, 32'h10);
    chk(32'(pin), 32'h1);
    bus(1'b1, 4'h8, 32'hffffffff);
    bus(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0);
    repeat (12) smp(10'h1a0);
    st();
    chk(rd & 32'h03ff0013, 32'h01a00000);
    pin_is(10'h1a2, 1'b1);
    pin_is(10'h1a8, 1'b0);
    pin_is(10'h1a2, 1'b0);
    pin_is(10'h198, 1'b1);
    @(negedge clk);
    chk(32'(edges), 32'h2);
    // threshold starts 0x60 below the wave midpoint, so steps clamp
    // each wave closes two min/max pairs, so at most two clamped steps per wave
    prev = 10'h1a0;
    for (int p = 0; p < 22; p++) begin
      wave(10'h180, 10'h280);
      st();
      thr = rd[25:16];
      chk(32'((thr > prev ? thr - prev : prev - thr) <= 10'h03c), 32'h1);
      if (p == 3) chk(rd & 32'h3, 32'h1);
      prev = thr;
    end
    chk(rd & 32'h03ff0003, 32'h02000002);
    // midpoint moves up by 0x10; filter needs four positive windows
    repeat (40) wave(10'h190, 10'h290);
    st();
    chk(rd & 32'h03ff0003, 32'h02000002);
    repeat (40) wave(10'h190, 10'h290);
    st();
    chk(32'(rd[25:16] inside {10'h201, 10'h202}), 32'h1);
    // waves below the threshold: extremes keep coming while the output stays silent
    repeat (2) wave(10'h100, 10'h1c0);
    st();
    chk(rd & 32'h3, 32'h0);
    // search ended near 0x180, so the first 0x200 sample toggles; only the dog re-searches
    repeat (300) smp(10'h200);
    st();
    chk(rd & 32'h03ff0013, 32'h02000000);
    bus(1'b1, 4'h0, 32'h002b6d50);
    st();
    chk(rd & 32'h03ff0013, 32'h01500000);
    pin_is(10'h130, 1'b0);
    pin_is(10'h170, 1'b1);
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h002b6d50);
    finish_test();
  end

  // cuts a hang short well above the expected run length
  initial begin
    #2ms;
    bad_count++;
    finish_test();
  end
endmodule
